// File: rtl/rvp_pkg.sv
/*
 * Package for the reset and vector placement block: vector slot layout,
 * fixed addresses, fuse encoding and the packed request/answer carriers.
 * Assumes a word-addressed program store with 13-bit word addresses.
 */
package rvp_pkg;

    // ****************************************************************
    // Address layout
    // ****************************************************************
    localparam int RVP_AW = 13;
    localparam logic [12:0] RVP_APP_RESET_ADDR = 13'h0000;
    localparam logic [12:0] RVP_APP_TABLE_START = 13'h0001;
    localparam logic [12:0] RVP_BOOT_TABLE_OFFSET = 13'h0002;
    localparam logic [12:0] RVP_SLOT_WORDS = 13'h0002;
    localparam logic [12:0] RVP_LAST_SLOT_OFFSET = 13'h0032;
    localparam int RVP_NUM_VECTORS = 25;
    localparam logic [4:0] RVP_IRQ_MAX = 5'h19;

    // Fuse encoding: one is unprogrammed, zero is programmed.
    localparam logic RVP_FUSE_UNPROGRAMMED = 1'b1;
    localparam logic RVP_FUSE_PROGRAMMED = 1'b0;

    // Default boot reset address; really set by the boot-size setting.
    localparam logic [12:0] RVP_BOOT_RESET_DEFAULT = 13'h1C00;

    // Reset values of the held control bits.
    localparam logic RVP_RELOCATE_RESET = 1'b0;
    localparam logic RVP_FUSE_RESET = 1'b1;

    // ****************************************************************
    // Vector numbers in slot order (slot 0 is reset)
    // ****************************************************************
    typedef enum logic [4:0] {
        RVP_V_RESET = 5'h00,
        RVP_V_EXTERNAL_IRQ_ZERO = 5'h01,
        RVP_V_EXTERNAL_IRQ_ONE = 5'h02,
        RVP_V_PIN_CHANGE_GROUP_ZERO = 5'h03,
        RVP_V_PIN_CHANGE_GROUP_ONE = 5'h04,
        RVP_V_PIN_CHANGE_GROUP_TWO = 5'h05,
        RVP_V_WATCHDOG = 5'h06,
        RVP_V_NONVOLATILE_READY = 5'h16,
        RVP_V_COMPARATOR_EVENT = 5'h17,
        RVP_V_TWO_WIRE = 5'h18,
        RVP_V_PROGRAM_STORE_READY = 5'h19
    } rvp_vector_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic [4:0] irq;
    } rvp_take_t;

    typedef struct packed {
        logic valid;
        logic [12:0] addr;
    } rvp_fetch_t;

endpackage : rvp_pkg

// File: rtl/rvp_slot_rom.sv
/*
 * Small registered lookup of the slot offset for every vector number.
 * Assumes the caller holds the vector number stable for one cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module rvp_slot_rom #(
    parameter int DEPTH = 26
) (
    // Clocking
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Lookup
    input wire logic [4:0] index,
    output logic [12:0] offset
);
    import rvp_pkg::*;

    logic [12:0] table_mem [DEPTH];

    // Numbers past the table read as zero, not unknown, so the address
    // output stays clean while idle junk sits on the number lines.
    wire in_range = (int'(index) < DEPTH);

    // The table is a constant, so it is built once from the slot size.
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            table_mem[i] = 13'(i) * RVP_SLOT_WORDS;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offset <= 13'h0000;
        end else if (ce) begin
            offset <= in_range ? table_mem[index] : 13'h0000;
        end
    end

endmodule : rvp_slot_rom
`default_nettype wire

// File: rtl/rvp_vector_place.sv
/*
 * Reset and interrupt vector placement. Chooses where the core starts
 * after reset and where each taken interrupt is fetched from.
 * Assumes the core raises a take request only for an interrupt that it
 * actually accepts, and that fuse and boot address are stable straps.
 */
// What this block does
// - With relocation set, every interrupt vector address is its slot plus the boot section start.
// - Execution after reset starts at 0x000 with the fuse unprogrammed, else at the boot address.
// - The table starts at 0x001 with relocation clear, else at boot address plus 0x0002.
// - A fuse value of one means unprogrammed and zero means programmed.
// - A vector slot is fetched only when its interrupt is really taken.
// - Reset vector and table may lie in different sections independently.
// - Each vector has a two-word slot, reset at offset zero and the last at 0x0032.
`timescale 1ns/1ns
`default_nettype none
module rvp_vector_place #(
    parameter logic [12:0] BOOT_RESET_ADDR = rvp_pkg::RVP_BOOT_RESET_DEFAULT
) (
    // Clocking
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Straps and control
    input wire logic boot_reset_fuse,
    input wire logic vector_relocate_select,
    // Core side
    input wire rvp_pkg::rvp_take_t take,
    output rvp_pkg::rvp_fetch_t fetch,
    output logic [12:0] reset_addr,
    output logic [12:0] table_start,
    output logic reset_fetch_valid
);
    import rvp_pkg::*;

    // ****************************************************************
    // Straps caught after reset release
    // ****************************************************************
    logic fuse_reg;
    logic fuse_taken_reg;
    logic relocate_reg;

    // The fuse is caught once after release, since an async reset may
    // only load constants; relocation follows software at any time.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fuse_reg <= RVP_FUSE_RESET;
            fuse_taken_reg <= 1'b0;
            relocate_reg <= RVP_RELOCATE_RESET;
        end else if (ce) begin
            if (!fuse_taken_reg) begin
                fuse_reg <= boot_reset_fuse;
            end
            fuse_taken_reg <= 1'b1;
            relocate_reg <= vector_relocate_select;
        end
    end

    // ****************************************************************
    // Placement decode
    // ****************************************************************
    function automatic logic [12:0] place_base(input logic moved, input logic [12:0] boot);
        place_base = moved ? boot : 13'h0000;
    endfunction : place_base

    wire fuse_programmed = (fuse_reg == RVP_FUSE_PROGRAMMED);
    // Reset and table bases are chosen apart, so each can sit in a
    // different section.
    wire [12:0] reset_next = place_base(fuse_programmed, BOOT_RESET_ADDR);
    wire [12:0] table_next = relocate_reg ? 13'(BOOT_RESET_ADDR + RVP_BOOT_TABLE_OFFSET)
                                          : RVP_APP_TABLE_START;
    wire [12:0] irq_base = place_base(relocate_reg, BOOT_RESET_ADDR);
    wire irq_ok = take.valid && (take.irq != 5'h00) && (take.irq <= RVP_IRQ_MAX);

    // ****************************************************************
    // Slot lookup and fetch answer
    // ****************************************************************
    logic [12:0] slot_offset;
    logic pend_reg;
    logic [12:0] base_reg;

    rvp_slot_rom #(.DEPTH(RVP_NUM_VECTORS + 1)) u_rom (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .index(take.irq),
        .offset(slot_offset)
    );

    // The answer appears two cycles after the take: one for the slot
    // lookup, one for the address register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_reg <= 1'b0;
            base_reg <= 13'h0000;
            fetch <= '0;
            reset_addr <= RVP_APP_RESET_ADDR;
            table_start <= RVP_APP_TABLE_START;
            reset_fetch_valid <= 1'b0;
        end else if (ce) begin
            pend_reg <= irq_ok;
            base_reg <= irq_base;
            fetch.valid <= pend_reg;
            fetch.addr <= 13'(base_reg + slot_offset);
            reset_addr <= reset_next;
            table_start <= table_next;
            reset_fetch_valid <= fuse_taken_reg;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_take;
        ce && irq_ok;
    endsequence

    property p_fetch_only_taken;
        @(posedge clk) disable iff (!nrst)
        (ce && fetch.valid && $past(ce) && $past(ce, 2)) |-> $past(irq_ok, 2);
    endproperty
    a_fetch_only_taken: assert property (p_fetch_only_taken)
        else $error("fetch without a taken interrupt");

    property p_fetch_after_take;
        @(posedge clk) disable iff (!nrst)
        s_take ##1 ce ##1 ce |-> fetch.valid;
    endproperty
    a_fetch_after_take: assert property (p_fetch_after_take)
        else $error("taken interrupt not fetched");

    property p_slot_addr;
        @(posedge clk) disable iff (!nrst)
        s_take ##1 ce ##1 ce |->
            fetch.addr == $past(irq_base, 2) + 13'($past(take.irq, 2)) * 13'h0002;
    endproperty
    a_slot_addr: assert property (p_slot_addr)
        else $error("slot address is not base plus two words per vector");

    property p_relocated;
        @(posedge clk) disable iff (!nrst)
        s_take ##0 relocate_reg ##1 ce ##1 ce |-> fetch.addr >= BOOT_RESET_ADDR;
    endproperty
    a_relocated: assert property (p_relocated)
        else $error("relocated vector below boot start");

    property p_reset_app;
        @(posedge clk) disable iff (!nrst)
        (ce && fuse_taken_reg && fuse_reg) |=> (!ce || reset_addr == 13'h0000);
    endproperty
    a_reset_app: assert property (p_reset_app)
        else $error("unprogrammed fuse must start at zero");

    property p_reset_boot;
        @(posedge clk) disable iff (!nrst)
        (ce && fuse_taken_reg && !fuse_reg) |=> (!ce || reset_addr == BOOT_RESET_ADDR);
    endproperty
    a_reset_boot: assert property (p_reset_boot)
        else $error("programmed fuse must start at boot address");

    property p_table_app;
        @(posedge clk) disable iff (!nrst)
        (ce && !relocate_reg) |=> (!ce || table_start == 13'h0001);
    endproperty
    a_table_app: assert property (p_table_app)
        else $error("table must start at one");

    property p_table_boot;
        @(posedge clk) disable iff (!nrst)
        (ce && relocate_reg) |=> (!ce || table_start == BOOT_RESET_ADDR + 13'h0002);
    endproperty
    a_table_boot: assert property (p_table_boot)
        else $error("relocated table must start two past boot address");

    property p_independent;
        @(posedge clk) disable iff (!nrst)
        (ce && fuse_taken_reg && fuse_reg && relocate_reg) |=>
            (!ce || (reset_addr == 13'h0000 && table_start != 13'h0001));
    endproperty
    a_independent: assert property (p_independent)
        else $error("reset and table sections not independent");

    // A refused number leaves the pipe quiet; the core would otherwise
    // jump through a slot that no source owns.
    sequence s_refused;
        ce && !irq_ok;
    endsequence

    sequence s_drain;
        ce ##1 ce;
    endsequence

    property p_refused_quiet;
        @(posedge clk) disable iff (!nrst)
        s_refused ##1 s_drain |-> !fetch.valid;
    endproperty
    a_refused_quiet: assert property (p_refused_quiet)
        else $error("refused number produced a fetch");

    property p_app_window;
        @(posedge clk) disable iff (!nrst)
        s_take ##0 !relocate_reg ##1 s_drain |-> fetch.addr <= RVP_LAST_SLOT_OFFSET;
    endproperty
    a_app_window: assert property (p_app_window)
        else $error("vector outside the application slot window");

    property p_last_slot;
        @(posedge clk) disable iff (!nrst)
        s_take ##0 (take.irq == RVP_V_PROGRAM_STORE_READY) ##0 !relocate_reg ##1 s_drain |->
            fetch.addr == RVP_LAST_SLOT_OFFSET;
    endproperty
    a_last_slot: assert property (p_last_slot)
        else $error("last vector not at the last slot");

    property p_fuse_held;
        @(posedge clk) disable iff (!nrst)
        (ce && fuse_taken_reg) |=> $stable(fuse_reg);
    endproperty
    a_fuse_held: assert property (p_fuse_held)
        else $error("caught fuse moved after release");

    property p_start_valid;
        @(posedge clk) disable iff (!nrst)
        (ce && fuse_taken_reg) |=> reset_fetch_valid;
    endproperty
    a_start_valid: assert property (p_start_valid)
        else $error("start address not flagged valid");

    property p_start_not_early;
        @(posedge clk) disable iff (!nrst)
        !fuse_taken_reg |-> !reset_fetch_valid;
    endproperty
    a_start_not_early: assert property (p_start_not_early)
        else $error("start address flagged before the fuse was caught");

endmodule : rvp_vector_place
`default_nettype wire

// File: tb/rvp_core_model.sv
/*
 * Behavioural processor core that raises interrupt takes.
 * Assumes its tasks are called just after a rising clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module rvp_core_model (
    // Clocking
    input wire logic clk,
    // Take requests
    output var rvp_pkg::rvp_take_t take
);
    import rvp_pkg::*;

    initial take = '0;

    // A take is raised for any number it is given, with no check that the core accepts it.
    task automatic send(input logic [4:0] irq);
        take <= {1'b1, irq};
        @(posedge clk);
    endtask : send

    // Idle number lines carry junk, so a design reading them unqualified is caught.
    task automatic rest(input int n);
        repeat (n) begin
            take <= {1'b0, 5'($urandom)};
            @(posedge clk);
        end
    endtask : rest
endmodule : rvp_core_model
`default_nettype wire

// File: tb/reset_vector_placement_tb.sv
/*
 * Self-checking bench for the vector placement block.
 * Assumes the core model drives takes; the bench also moves the straps after reset release.
 */
`timescale 1ns/1ns
`default_nettype none
module reset_vector_placement_tb;
    import rvp_pkg::*;

    localparam logic [12:0] BOOT = 13'h0E00;
    logic clk = 1'b0;
    logic nrst;
    logic ce;
    logic boot_reset_fuse;
    logic vector_relocate_select;
    logic boot_fuse = 1'b1;
    logic ok;
    rvp_take_t take;
    rvp_fetch_t fetch;
    logic [12:0] reset_addr;
    logic [12:0] table_start;
    logic rfv;
    logic [13:0] p0 = '0;
    logic [13:0] p1 = '0;
    int error_cnt = 0;
    int compares = 0;
    int seed;

    always #10 clk = ~clk;

    rvp_vector_place #(.BOOT_RESET_ADDR(BOOT)) dut (.clk(clk), .nrst(nrst), .ce(ce),
        .boot_reset_fuse(boot_reset_fuse), .vector_relocate_select(vector_relocate_select),
        .take(take), .fetch(fetch), .reset_addr(reset_addr), .table_start(table_start),
        .reset_fetch_valid(rfv));
    rvp_core_model core (.clk(clk), .take(take));

    task automatic check(input logic [27:0] seen, input logic [27:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // ****************************************************************
    // Reference pipeline: a take shows as a fetch two enabled edges on.
    // ****************************************************************
    always @(posedge clk) begin
        if (!nrst) begin
            p0 = '0;
            p1 = '0;
        end else begin
            check({14'h0, fetch.valid, fetch.valid ? fetch.addr : 13'h0}, {14'h0, p1}, "fetch");
            if (ce) begin
                ok = take.valid === 1'b1 && take.irq >= 5'h01 && take.irq <= 5'h19;
                p1 = p0;
                p0 = ok ? {1'b1, (vector_relocate_select ? BOOT : 13'h0) + {7'h0, take.irq, 1'b0}} : 14'h0;
            end
        end
    end

    task automatic check_place;
        check({1'b0, reset_addr, table_start, rfv}, {1'b0, boot_fuse ? 13'h0 : BOOT,
            vector_relocate_select ? BOOT + 13'h0002 : 13'h0001, 1'b1}, "place");
    endtask : check_place

    task automatic do_reset(input logic f);
        nrst <= 1'b0;
        ce <= 1'b1;
        boot_reset_fuse <= f;
        boot_fuse = f;
        repeat (12) @(posedge clk);
        check({fetch.valid, reset_addr, table_start, rfv}, {1'b0, 13'h0, 13'h0001, 1'b0}, "reset");
        nrst <= 1'b1;
        core.rest(3);
    endtask : do_reset

    initial begin
        #(20 * 3000);
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        boot_reset_fuse = 1'b1;
        vector_relocate_select = 1'b0;
        seed = $urandom(88);
        // Every fuse and relocation pairing, every slot back to back, refusals at both ends.
        for (int f = 1; f >= 0; f--) begin
            for (int r = 0; r < 2; r++) begin
                do_reset(f[0]);
                vector_relocate_select <= r[0];
                core.rest(3);
                check_place();
                for (int i = 0; i <= 26; i++) core.send(5'(i));
                core.rest(3);
                $display("test placement fuse %0d relocate %0d done", f, r);
            end
        end
        // Random takes, including out-of-range numbers, under a stuttering enable.
        for (int i = 0; i < 200; i++) begin
            ce <= 1'($urandom);
            if ($urandom % 3 != 0)
                core.send(5'($urandom));
            else
                core.rest(1);
        end
        ce <= 1'b1;
        core.rest(4);
        $display("test random takes done");
        // The fuse is caught once; moving it later must not move the reset address.
        boot_reset_fuse <= ~boot_reset_fuse;
        vector_relocate_select <= ~vector_relocate_select;
        core.rest(3);
        check_place();
        $display("test late strap change done");
        // Reset in mid-traffic drops the pending fetches.
        core.send(5'h19);
        core.send(5'h01);
        do_reset(1'b1);
        core.send(5'h19);
        core.rest(3);
        check_place();
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : reset_vector_placement_tb
`default_nettype wire
